// ===== hdl/asrp_clock_ctrl.v
// sample-rate and pll clock control with apb register access
// assumes ref_clk is the master clock; the analog pll is modelled as its
// ratio, and its divided output as one-cycle enables at most one per ref_clk
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "asrp_regs.vh"

module asrp_clock_ctrl
(
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [2:0]  coef_set,
    output reg         coef_valid,
    output reg         pll_running,
    output reg  [27:0] pll_ratio,
    output reg         system_clock_en,
    output reg         sample_tick,
    output reg         gpio_out
);

    // register storage
    reg [15:0] pwr_mgmt_r;
    reg [15:0] clock_gen_r;
    reg [15:0] add_ctrl_r;
    reg [15:0] gpio_ctrl_r;
    reg [15:0] pll_int_r;
    reg [5:0]  frac_high_r;
    reg [8:0]  frac_mid_r;
    reg [8:0]  frac_low_r;

    // clock path state
    reg [35:0] acc_r;
    reg [35:0] acc_nxt;
    reg [7:0]  fs_cnt_r;
    reg [1:0]  op_cnt_r;
    reg        gpio_clk_r;
    reg        sys_en_nxt;

    wire [5:0]  idx;
    wire        setup_ph;
    wire        wr_en;
    wire        hit;
    wire [23:0] pll_fraction_ratio;
    wire [3:0]  pll_integer_ratio;
    wire        fraction_on;
    wire        pll_shutdown;
    wire [1:0]  pll_input_prescale;
    wire        pll_enable;
    wire [1:0]  midrail_reference_select;
    wire [2:0]  sample_rate_select;
    wire        internal_clock_source;
    wire [2:0]  system_clock_divider;
    wire [27:0] ratio_eff;
    wire [35:0] ratio_pre;
    wire [35:0] inc;
    wire [35:0] thr;
    wire        run_nxt;

    // register index valid check, shared by write and read decode
    function is_mapped;
        input [5:0] i;
        begin
            case (i)
                `ASRP_IDX_PWR_MGMT_ONE,
                `ASRP_IDX_CLOCK_GEN,
                `ASRP_IDX_ADD_CTRL,
                `ASRP_IDX_GPIO_CTRL,
                `ASRP_IDX_PLL_INT,
                `ASRP_IDX_FRAC_HIGH,
                `ASRP_IDX_FRAC_MID,
                `ASRP_IDX_FRAC_LOW,
                `ASRP_IDX_STATUS: is_mapped = 1'b1;
                default:          is_mapped = 1'b0;
            endcase
        end
    endfunction

    // divide ratio in half steps
    function [4:0] div_halves;
        input [2:0] code;
        begin
            case (code)
                3'h0:    div_halves = 5'h02;
                3'h1:    div_halves = 5'h03;
                3'h2:    div_halves = 5'h04;
                3'h3:    div_halves = 5'h06;
                3'h4:    div_halves = 5'h08;
                3'h5:    div_halves = 5'h0c;
                3'h6:    div_halves = 5'h10;
                default: div_halves = 5'h18;
            endcase
        end
    endfunction

    // apb slave, zero wait states
    assign idx      = paddr[7:2];
    assign hit      = is_mapped(idx);
    assign setup_ph = psel & ~penable;
    assign wr_en    = psel & penable & pwrite & hit;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~hit;

    // field views
    assign pll_enable               = pwr_mgmt_r[`ASRP_PLL_ENABLE_BIT];
    assign midrail_reference_select = pwr_mgmt_r[`ASRP_MIDRAIL_MSB:0];
    assign sample_rate_select       = add_ctrl_r[`ASRP_SR_MSB:`ASRP_SR_LSB];
    assign internal_clock_source    = clock_gen_r[`ASRP_CLK_SRC_BIT];
    assign system_clock_divider     = clock_gen_r[`ASRP_SYSDIV_MSB:`ASRP_SYSDIV_LSB];
    assign pll_shutdown             = pll_int_r[`ASRP_SHUTDOWN_BIT];
    assign fraction_on              = pll_int_r[`ASRP_FRAC_ON_BIT];
    assign pll_input_prescale       = pll_int_r[`ASRP_PRESCALE_MSB:`ASRP_PRESCALE_LSB];
    assign pll_integer_ratio        = pll_int_r[`ASRP_INT_MSB:0];

    assign pll_fraction_ratio = {frac_high_r, frac_mid_r, frac_low_r};

    // fraction ignored while disabled, stored value untouched
    assign ratio_eff = {pll_integer_ratio,
                        fraction_on ? pll_fraction_ratio : 24'h00_0000};

    assign run_nxt = pll_enable & ~pll_shutdown
                     & (midrail_reference_select != 2'b00);

    // prescaled ratio, in units of 2^-24 reference cycles
    assign ratio_pre = (pll_input_prescale == 2'b00) ? {7'h00, ratio_eff, 1'b0} :
                       (pll_input_prescale == 2'b01) ? {8'h00, ratio_eff} :
                       (pll_input_prescale == 2'b10) ? {9'h000, ratio_eff[27:1]} :
                                                       {10'h000, ratio_eff[27:2]};

    // pll output after fixed divide by four, or mclk when selected
    assign inc = ~internal_clock_source ? `ASRP_ONE_FIXED :
                 pll_running ? {2'b00, ratio_pre[35:2]} : 36'h0_0000_0000;

    // threshold: divider halves times 2^23
    assign thr = {8'h00, div_halves(system_clock_divider), 23'h00_0000};

    // register writes
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_mgmt_r  <= `ASRP_RST_PWR_MGMT;
            clock_gen_r <= `ASRP_RST_CLOCK_GEN;
            add_ctrl_r  <= `ASRP_RST_ADD_CTRL;
            gpio_ctrl_r <= `ASRP_RST_GPIO_CTRL;
            pll_int_r   <= `ASRP_RST_PLL_INT;
            frac_high_r <= `ASRP_RST_FRAC_HIGH;
            frac_mid_r  <= `ASRP_RST_FRAC_MID;
            frac_low_r  <= `ASRP_RST_FRAC_LOW;
        end
        else if (wr_en)
        begin
            case (idx)
                `ASRP_IDX_PWR_MGMT_ONE: pwr_mgmt_r  <= pwdata[15:0];
                `ASRP_IDX_CLOCK_GEN:    clock_gen_r <= pwdata[15:0];
                `ASRP_IDX_ADD_CTRL:     add_ctrl_r  <= pwdata[15:0];
                `ASRP_IDX_GPIO_CTRL:    gpio_ctrl_r <= pwdata[15:0];
                `ASRP_IDX_PLL_INT:      pll_int_r   <= pwdata[15:0];
                `ASRP_IDX_FRAC_HIGH:    frac_high_r <= pwdata[5:0];
                `ASRP_IDX_FRAC_MID:     frac_mid_r  <= pwdata[8:0];
                `ASRP_IDX_FRAC_LOW:     frac_low_r  <= pwdata[8:0];
                default:                pwr_mgmt_r  <= pwr_mgmt_r;
            endcase
        end
    end

    // read data captured in the setup cycle
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_ph)
        begin
            case (idx)
                `ASRP_IDX_PWR_MGMT_ONE: prdata <= {16'h0000, pwr_mgmt_r};
                `ASRP_IDX_CLOCK_GEN:    prdata <= {16'h0000, clock_gen_r};
                `ASRP_IDX_ADD_CTRL:     prdata <= {16'h0000, add_ctrl_r};
                `ASRP_IDX_GPIO_CTRL:    prdata <= {16'h0000, gpio_ctrl_r};
                `ASRP_IDX_PLL_INT:      prdata <= {16'h0000, pll_int_r};
                `ASRP_IDX_FRAC_HIGH:    prdata <= {26'h000_0000, frac_high_r};
                `ASRP_IDX_FRAC_MID:     prdata <= {23'h00_0000, frac_mid_r};
                `ASRP_IDX_FRAC_LOW:     prdata <= {23'h00_0000, frac_low_r};
                `ASRP_IDX_STATUS:       prdata <= {26'h000_0000, coef_valid, coef_set,
                                                   fraction_on & pll_running,
                                                   pll_running};
                default:                prdata <= 32'h0000_0000;
            endcase
        end
    end

    // coefficient set: reserved codes keep the last valid set
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            coef_set   <= 3'h0;
            coef_valid <= 1'b1;
        end
        else if (sample_rate_select <= `ASRP_SR_LAST_VALID)
        begin
            coef_set   <= sample_rate_select;
            coef_valid <= 1'b1;
        end
        else
        begin
            coef_valid <= 1'b0;
        end
    end

    // pll state and ratio
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pll_running <= 1'b0;
            pll_ratio   <= 28'h000_0000;
        end
        else
        begin
            pll_running <= run_nxt;
            pll_ratio   <= ratio_eff;
        end
    end

    // system clock divider by accumulation, capped at one pulse per cycle
    always @*
    begin
        acc_nxt    = acc_r + inc;
        sys_en_nxt = 1'b0;
        if (acc_nxt >= thr)
        begin
            acc_nxt    = acc_nxt - thr;
            sys_en_nxt = 1'b1;
            if (acc_nxt >= thr)
            begin
                acc_nxt = thr;
            end
        end
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_r           <= 36'h0_0000_0000;
            system_clock_en <= 1'b0;
        end
        else
        begin
            acc_r           <= acc_nxt;
            system_clock_en <= sys_en_nxt;
        end
    end

    // sample tick every 256 system clocks
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fs_cnt_r    <= 8'h00;
            sample_tick <= 1'b0;
        end
        else
        begin
            sample_tick <= 1'b0;
            if (system_clock_en)
            begin
                fs_cnt_r <= fs_cnt_r + 8'h01;
                if (fs_cnt_r == 8'hff)
                begin
                    sample_tick <= 1'b1;
                end
            end
        end
    end

    // gpio clock: system clock divided by 1..4, then toggled
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_cnt_r   <= 2'b00;
            gpio_clk_r <= 1'b0;
        end
        else if (system_clock_en)
        begin
            if (op_cnt_r >= gpio_ctrl_r[`ASRP_OPDIV_MSB:`ASRP_OPDIV_LSB])
            begin
                op_cnt_r   <= 2'b00;
                gpio_clk_r <= ~gpio_clk_r;
            end
            else
            begin
                op_cnt_r <= op_cnt_r + 2'b01;
            end
        end
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_out <= 1'b0;
        end
        else
        begin
            case (gpio_ctrl_r[`ASRP_GPIO_SEL_MSB:0])
                `ASRP_GPIO_SEL_SYSTEM_CLOCK:
                    gpio_out <= gpio_clk_r ^ gpio_ctrl_r[`ASRP_GPIO_POL_BIT];
                `ASRP_GPIO_SEL_LOCK:
                    gpio_out <= pll_running ^ gpio_ctrl_r[`ASRP_GPIO_POL_BIT];
                default:
                    gpio_out <= gpio_ctrl_r[`ASRP_GPIO_POL_BIT];
            endcase
        end
    end

endmodule // asrp_clock_ctrl

// ===== hdl/asrp_regs.vh
// register indices, field positions, reset values for the clock control block
// assumes byte address = 4 * register index on a 32-bit apb bus
`ifndef ASRP_REGS_VH
`define ASRP_REGS_VH

// register indices
`define ASRP_IDX_PWR_MGMT_ONE   6'h01
`define ASRP_IDX_CLOCK_GEN      6'h06
`define ASRP_IDX_ADD_CTRL       6'h07
`define ASRP_IDX_GPIO_CTRL      6'h08
`define ASRP_IDX_PLL_INT        6'h24
`define ASRP_IDX_FRAC_HIGH      6'h25
`define ASRP_IDX_FRAC_MID       6'h26
`define ASRP_IDX_FRAC_LOW       6'h27
`define ASRP_IDX_STATUS         6'h30

// field positions
`define ASRP_PLL_ENABLE_BIT     5
`define ASRP_MIDRAIL_MSB        1
`define ASRP_SR_MSB             3
`define ASRP_SR_LSB             1
`define ASRP_CLK_SRC_BIT        8
`define ASRP_SYSDIV_MSB         7
`define ASRP_SYSDIV_LSB         5
`define ASRP_SHUTDOWN_BIT       7
`define ASRP_FRAC_ON_BIT        6
`define ASRP_PRESCALE_MSB       5
`define ASRP_PRESCALE_LSB       4
`define ASRP_INT_MSB            3
`define ASRP_OPDIV_MSB          5
`define ASRP_OPDIV_LSB          4
`define ASRP_GPIO_POL_BIT       3
`define ASRP_GPIO_SEL_MSB       2

// reset values
`define ASRP_RST_PWR_MGMT       16'h0000
`define ASRP_RST_CLOCK_GEN      16'h0140
`define ASRP_RST_ADD_CTRL       16'h0000
`define ASRP_RST_GPIO_CTRL      16'h0000
`define ASRP_RST_PLL_INT        16'h0048
`define ASRP_RST_FRAC_HIGH      6'h0c
`define ASRP_RST_FRAC_MID       9'h093
`define ASRP_RST_FRAC_LOW       9'h0e9

// encodings and timing
`define ASRP_SR_LAST_VALID      3'h5
`define ASRP_GPIO_SEL_SYSTEM_CLOCK    3'h4
`define ASRP_GPIO_SEL_LOCK      3'h5
`define ASRP_FS_RATIO           9'h100
`define ASRP_ONE_FIXED          36'h0_0100_0000

`endif

// ===== verification/asrp_ref_source.sv
// reference master clock source at the far side of the clock control block
// assumes a free running 25 mhz oscillator
`timescale 1ns/1ps
module asrp_ref_source
(
    output reg ref_clk
);
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;
endmodule // asrp_ref_source

// ===== verification/asrp_clock_ctrl_monitor.sv
// port checker for the clock control block
// assumes one ref_clk domain and async active-low rst_n
`timescale 1ns/1ps
module asrp_clock_ctrl_monitor
(
    input wire        ref_clk,
    input wire        rst_n,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [2:0]  coef_set,
    input wire        coef_valid,
    input wire        pll_running,
    input wire [27:0] pll_ratio,
    input wire        system_clock_en,
    input wire        sample_tick,
    input wire        gpio_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire       wr = psel && penable && pwrite;
    wire [5:0] ix = paddr[7:2];
    AST_ENABLE_OFF:
        assert property (wr && ix == 6'h01 && !pwdata[5] |-> ##2 !pll_running)
        else $error("pll runs with enable clear");
    AST_MIDRAIL_OFF:
        assert property (wr && ix == 6'h01 && pwdata[1:0] == 2'h0 |-> ##2 !pll_running)
        else $error("pll runs with midrail select zero");
    AST_SHUTDOWN_OFF:
        assert property (wr && ix == 6'h24 && pwdata[7] |-> ##2 !pll_running)
        else $error("pll runs while shut down");
    AST_COEF_PICK:
        assert property (wr && ix == 6'h07 && pwdata[3:1] < 3'h6
            |-> ##2 coef_valid && coef_set == $past(pwdata[3:1], 2))
        else $error("coefficient set wrong");
    AST_COEF_RESERVED:
        assert property (wr && ix == 6'h07 && pwdata[3:1] > 3'h5 |-> ##2 !coef_valid)
        else $error("reserved rate code accepted");
    AST_INTEGER_ONLY:
        assert property (wr && ix == 6'h24 && !pwdata[6]
            |-> ##2 pll_ratio == {$past(pwdata[3:0], 2), 24'h00_0000})
        else $error("ratio not integer only");
    AST_FRACTION_HIGH:
        assert property (wr && ix == 6'h25 |-> ##2
            (pll_ratio[23:0] == 24'h00_0000 || pll_ratio[23:18] == $past(pwdata[5:0], 2)))
        else $error("fraction high bits misplaced");
    AST_MCLK_FULL_RATE:
        assert property (wr && ix == 6'h06 && pwdata[8:5] == 4'h0 |-> ##4 system_clock_en [*4])
        else $error("system clock not every cycle");
    AST_GPIO_LOCK:
        assert property (wr && ix == 6'h08 && pwdata[2:0] == 3'h5 && $stable(pll_running)
            |-> ##3 gpio_out == (pll_running ^ $past(pwdata[3], 3)))
        else $error("gpio does not follow pll state");
    cover property (sample_tick);
    cover property (pll_running && pll_ratio[23:0] != 24'h00_0000);
    cover property (pslverr);
endmodule // asrp_clock_ctrl_monitor

// ===== verification/asrp_clock_ctrl_tb.sv
// self-checking bench for the clock control block
// assumes the reference source model makes ref_clk; apb master driven here
`timescale 1ns/1ps
module asrp_clock_ctrl_tb;
    localparam [7:0] A_PWR = 8'h04;
    localparam [7:0] A_CLK = 8'h18;
    localparam [7:0] A_ADD = 8'h1c;
    localparam [7:0] A_GPO = 8'h20;
    localparam [7:0] A_INT = 8'h90;
    localparam [7:0] A_FH  = 8'h94;
    localparam [7:0] A_FM  = 8'h98;
    localparam [7:0] A_FL  = 8'h9c;
    wire        ref_clk;
    reg         rst_n;
    reg  [7:0]  paddr;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire [2:0]  coef_set;
    wire        coef_valid;
    wire        pll_running;
    wire [27:0] pll_ratio;
    wire        system_clock_en;
    wire        sample_tick;
    wire        gpio_out;
    integer     mismatches;
    integer     n_tests;
    integer     cyc;
    integer     i;
    integer     cnt;
    reg  [31:0] rd;
    reg         er;

    asrp_ref_source u_ref (.ref_clk(ref_clk));
    asrp_clock_ctrl u_dut
    (
        .ref_clk         (ref_clk),
        .rst_n           (rst_n),
        .paddr           (paddr),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .coef_set        (coef_set),
        .coef_valid      (coef_valid),
        .pll_running     (pll_running),
        .pll_ratio       (pll_ratio),
        .system_clock_en (system_clock_en),
        .sample_tick     (sample_tick),
        .gpio_out        (gpio_out)
    );

    task report_and_stop;
    begin
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task apb(input [7:0] a, input w, input [31:0] d);
    begin
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task settle;
    begin
        repeat (3) @(posedge ref_clk);
        #1;
    end
    endtask

    // count system clock enables over 48 cycles; whole divider periods fit, so exact
    task rate(input [15:0] iv, input [15:0] cv, input integer e);
    begin
        apb(A_INT, 1'b1, {16'h0000, iv});
        apb(A_CLK, 1'b1, {16'h0000, cv});
        repeat (4) @(posedge ref_clk);
        cnt = 0;
        repeat (48)
        begin
            @(posedge ref_clk);
            cnt = cnt + (system_clock_en === 1'b1);
        end
        check(cnt, e);
    end
    endtask

    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end

    initial
    begin
        rst_n = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(A_PWR, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(A_ADD, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(A_CLK, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0140);
        apb(A_INT, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0048);
        apb(A_FH, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_000c);
        apb(A_FM, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0093);
        apb(A_FL, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_00e9);
        check({4'h0, pll_ratio}, 32'h0831_26e9);
        apb(8'h40, 1'b1, 32'h0000_ffff);
        apb(8'h40, 1'b0, 32'h0000_0000);
        check({er, rd[30:0]}, 32'h8000_0000);
        for (i = 0; i < 8; i = i + 1)
        begin
            apb(A_ADD, 1'b1, i << 1);
            settle;
            check({28'h0, coef_valid, coef_set}, {28'h0, i < 6, (i < 6) ? i[2:0] : 3'h5});
        end
        // nearest code for an 11.025 khz rate
        apb(A_ADD, 1'b1, 32'h0000_0008);
        settle;
        check({28'h0, coef_valid, coef_set}, 32'h0000_000c);
        apb(A_PWR, 1'b1, 32'h0000_0021);
        settle;
        check({31'h0, pll_running}, 32'h0000_0001);
        apb(A_PWR, 1'b1, 32'h0000_0020);
        settle;
        check({31'h0, pll_running}, 32'h0000_0000);
        apb(A_PWR, 1'b1, 32'h0000_0001);
        settle;
        check({31'h0, pll_running}, 32'h0000_0000);
        apb(A_PWR, 1'b1, 32'h0000_0021);
        apb(A_INT, 1'b1, 32'h0000_00c8);
        settle;
        check({31'h0, pll_running}, 32'h0000_0000);
        apb(A_FH, 1'b1, 32'h0000_0021);
        apb(A_FM, 1'b1, 32'h0000_0161);
        apb(A_FL, 1'b1, 32'h0000_0026);
        apb(A_INT, 1'b1, 32'h0000_0057);
        settle;
        check({3'h0, pll_running, pll_ratio}, 32'h1786_c226);
        apb(A_INT, 1'b1, 32'h0000_0017);
        settle;
        check({4'h0, pll_ratio}, 32'h0700_0000);
        apb(A_INT, 1'b1, 32'h0000_0057);
        settle;
        check({4'h0, pll_ratio}, 32'h0786_c226);
        rate(16'h0018, 16'h01c0, 12);
        rate(16'h0008, 16'h01c0, 24);
        rate(16'h0018, 16'h0000, 48);
        rate(16'h0018, 16'h0020, 32);
        rate(16'h0018, 16'h00a0, 8);
        rate(16'h0028, 16'h01c0, 6);
        apb(A_CLK, 1'b1, 32'h0000_0000);
        @(posedge ref_clk);
        while (sample_tick !== 1'b1)
            @(posedge ref_clk);
        cnt = 0;
        do
        begin
            @(posedge ref_clk);
            cnt = cnt + 1;
        end
        while (sample_tick !== 1'b1);
        check(cnt, 32'h0000_0100);
        apb(A_GPO, 1'b1, 32'h0000_0005);
        settle;
        check({31'h0, gpio_out}, 32'h0000_0001);
        apb(A_GPO, 1'b1, 32'h0000_000d);
        settle;
        check({31'h0, gpio_out}, 32'h0000_0000);
        // divided system clock on gpio: toggles every second system clock
        apb(A_GPO, 1'b1, 32'h0000_0014);
        settle;
        cnt = 0;
        er = gpio_out;
        repeat (16)
        begin
            @(posedge ref_clk);
            #1;
            cnt = cnt + (gpio_out !== er);
            er = gpio_out;
        end
        check(cnt, 32'h0000_0008);
        // status: coef_valid, coef_set 4, fraction off, pll running
        apb(8'hc0, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0031);
        report_and_stop;
    end
endmodule // asrp_clock_ctrl_tb

bind asrp_clock_ctrl asrp_clock_ctrl_monitor u_mon
(
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .paddr           (paddr),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .coef_set        (coef_set),
    .coef_valid      (coef_valid),
    .pll_running     (pll_running),
    .pll_ratio       (pll_ratio),
    .system_clock_en (system_clock_en),
    .sample_tick     (sample_tick),
    .gpio_out        (gpio_out)
);
